// File: asph_pkg.sv
// Purpose: Shared constants and types for the converter serial host port.
// Assumes: 10 MHz system clock; straps arrive as two-bit pin states.
// Notes: Pin state codes: 00 low, 01 high, 10 floating, 11 invalid.
package asph_pkg;

  localparam int ASPH_CLK_PERIOD_NS = 100;
  localparam int ASPH_MOD_PERIOD_NS = 400;
  localparam int ASPH_HALF_MOD_NS = ASPH_MOD_PERIOD_NS / 2;
  localparam int ASPH_HALF_MOD_RAW =
    (ASPH_HALF_MOD_NS + ASPH_CLK_PERIOD_NS - 1) / ASPH_CLK_PERIOD_NS;
  localparam int ASPH_HALF_MOD_CYC =
    (ASPH_HALF_MOD_RAW < 1) ? 1 : ASPH_HALF_MOD_RAW;

  localparam int ASPH_NUM_CH = 4;
  localparam int ASPH_MAX_CH = 8;
  localparam int ASPH_HAM_BITS = 5;
  localparam int ASPH_CODE_POS_MAX = 29;
  localparam int ASPH_CS0_LSB = 12;

  localparam logic [5:0] ASPH_BITS_W16 = 6'h10;
  localparam logic [5:0] ASPH_BITS_W24 = 6'h18;
  localparam logic [5:0] ASPH_BITS_W32 = 6'h20;

  localparam logic [1:0] ASPH_STRAP_SETTLE = 2'h2;
  localparam logic [1:0] ASPH_STRAP_DONE = 2'h3;

  typedef enum logic [1:0] {
    ASPH_PIN_LOW = 2'b00,
    ASPH_PIN_HIGH = 2'b01,
    ASPH_PIN_FLOAT = 2'b10,
    ASPH_PIN_BAD = 2'b11
  } asph_pin_t;

  typedef enum logic [1:0] {
    ASPH_W16 = 2'b00,
    ASPH_W24 = 2'b01,
    ASPH_W32 = 2'b10
  } asph_wsz_t;

  typedef struct packed {
    asph_pin_t mode;
    asph_wsz_t wsz;
    logic ham_en;
    logic bad;
  } asph_cfg_t;

  localparam asph_cfg_t ASPH_CFG_RST = '{mode: ASPH_PIN_LOW,
    wsz: ASPH_W16, ham_en: 1'b0, bad: 1'b1};

  typedef struct packed {
    logic [23:0] data;
    logic fixed;
    logic err;
  } asph_rx_t;

endpackage : asph_pkg

// File: asph_serial_port.sv
// Purpose: Async-interrupt serial port of a sigma-delta converter, with
//   per-word Hamming protection.
// Assumes: sclk and cs_n come from the host; conversion results arrive
//   on the system clock; straps are static after power-up.
// Notes: Only the asynchronous interrupt mode drives the link.
`timescale 1ns/1ns
module asph_serial_port
  import asph_pkg::*;
#(
  parameter int NUM_CH = ASPH_NUM_CH,
  parameter int HALF_MOD_CYC = ASPH_HALF_MOD_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in_line,
  output logic serial_out_line,
  output logic serial_out_oe,
  output logic data_ready_n_line,
  input wire logic [1:0] interface_mode_strap,
  input wire logic [1:0] word_size_strap,
  input wire logic [1:0] hamming_strap,
  input wire logic conv_valid,
  input wire logic [NUM_CH-1:0][23:0] conv_data,
  input wire logic [15:0] status_word,
  input wire logic overrun_clear,
  output logic data_overrun_flag,
  output logic cmd_valid,
  output logic [15:0] cmd_word,
  output logic cmd_fixed,
  output logic cmd_error,
  output logic cfg_async_mode,
  output logic cfg_hamming_en,
  output logic [5:0] cfg_word_bits,
  output logic cfg_invalid
);

  localparam int CNT_W = $clog2(HALF_MOD_CYC + 1);

  initial begin
    if (NUM_CH < 1 || NUM_CH > ASPH_MAX_CH || HALF_MOD_CYC < 1) begin
      $error("asph_serial_port: unsupported parameter values");
    end
  end

  function automatic logic [5:0] asph_wbits(input asph_wsz_t w);
    case (w)
      ASPH_W32: return ASPH_BITS_W32;
      ASPH_W24: return ASPH_BITS_W24;
      default: return ASPH_BITS_W16;
    endcase
  endfunction : asph_wbits

  function automatic asph_cfg_t asph_straps(input asph_pin_t m0,
      input asph_pin_t m1, input asph_pin_t m2);
    asph_cfg_t c;
    c.mode = m0;
    c.ham_en = (m2 == ASPH_PIN_HIGH);
    case (m1)
      ASPH_PIN_HIGH: c.wsz = ASPH_W32;
      ASPH_PIN_LOW: c.wsz = ASPH_W24;
      default: c.wsz = ASPH_W16;
    endcase
    c.bad = (m2 == ASPH_PIN_FLOAT) || (m2 == ASPH_PIN_BAD)
      || (m1 == ASPH_PIN_BAD) || (m0 == ASPH_PIN_BAD)
      || (c.ham_en && m1 == ASPH_PIN_FLOAT);
    return c;
  endfunction : asph_straps

  // Positions run 1..29 from the LSB end; data bit 23 sits lowest.
  function automatic logic [7:0] asph_ham_byte(input logic [23:0] d);
    logic [4:0] h;
    logic [4:0] p5;
    int k;
    h = 5'h00;
    k = 23;
    for (int p = 1; p <= ASPH_CODE_POS_MAX; p++) begin
      p5 = 5'(p);
      if ((p5 & (p5 - 5'h01)) != 5'h00) begin
        for (int b = 0; b < ASPH_HAM_BITS; b++) begin
          if (p5[b]) h[b] = h[b] ^ d[k];
        end
        k = k - 1;
      end
    end
    // Hamming bits, overall parity and upper-half parity fill the check byte; bit 0 stays zero
    return {h, ^{d, h}, ^d[23:ASPH_CS0_LSB], 1'b0};
  endfunction : asph_ham_byte

  function automatic asph_rx_t asph_ham_check(input logic [23:0] d,
      input logic [7:0] hb);
    logic [7:0] calc;
    logic [4:0] syn;
    logic [4:0] p5;
    logic par_bad;
    logic [23:0] fx;
    int k;
    asph_rx_t r;
    calc = asph_ham_byte(d);
    syn = calc[7:3] ^ hb[7:3];
    par_bad = (^{d, hb[7:3]}) != hb[2];
    fx = d;
    k = 23;
    for (int p = 1; p <= ASPH_CODE_POS_MAX; p++) begin
      p5 = 5'(p);
      if ((p5 & (p5 - 5'h01)) != 5'h00) begin
        if (p5 == syn) fx[k] = ~fx[k];
        k = k - 1;
      end
    end
    r.data = (par_bad && syn != 5'h00) ? fx : d;
    r.fixed = par_bad;
    // Syndrome without parity slip, or beyond the code, is multi-bit
    r.err = (!par_bad && syn != 5'h00) || (5'(syn) > 5'd29)
      || (^r.data[23:ASPH_CS0_LSB] != hb[1]);
    return r;
  endfunction : asph_ham_check

  // Payload is left-justified; the Hamming byte follows it in bits 7:0
  // of a 32-bit word or in bits 15:8 of a 24-bit word.
  function automatic logic [31:0] asph_mk_word(input logic [23:0] p,
      input asph_wsz_t w, input logic he);
    logic [7:0] hb;
    hb = asph_ham_byte((w == ASPH_W24) ? {p[23:8], 8'h00} : p);
    case (w)
      ASPH_W32: return {p, he ? hb : 8'h00};
      ASPH_W24: return {p[23:8], he ? hb : p[7:0], 8'h00};
      default: return {p[23:8], 16'h0000};
    endcase
  endfunction : asph_mk_word

  typedef struct packed {
    logic [2:0] cs_sync;
    logic [1:0] sent_sync;
    logic [1:0] got_sync;
    logic [5:0] strap_s1;
    logic [5:0] strap_s2;
    logic [1:0] boot;
    asph_cfg_t cfg;
    logic pending;
    logic data_ready_n_line_n;
    logic [CNT_W-1:0] pulse_cnt;
    logic ovr;
    logic [NUM_CH:0][31:0] frame;
    logic [15:0] cmd;
    logic cmd_valid;
    logic cmd_fixed;
    logic cmd_err;
  } asph_main_t;

  typedef struct packed {
    logic drive;
    logic bit_out;
    logic [3:0] word;
    logic [4:0] bitn;
    logic done;
  } asph_tx_t;

  typedef struct packed {
    logic [5:0] cnt;
    logic [31:0] sh;
  } asph_rxs_t;

  asph_main_t st;
  asph_main_t nx;
  asph_tx_t tx;
  asph_tx_t tx_nx;
  asph_rxs_t rx;
  asph_rxs_t rx_nx;
  logic tx_sent_r;
  logic rx_got_r;
  logic [31:0] rx_cmd_r;
  logic [31:0] rx_word;
  logic [5:0] wb;
  logic link_en;
  logic cs_rise;
  logic take;
  logic ovr_evt;
  logic pend;
  logic [23:0] rx_field;
  logic [7:0] rx_hb;
  asph_rx_t rxd;

  assign wb = asph_wbits(st.cfg.wsz);
  assign link_en = (st.cfg.mode == ASPH_PIN_HIGH) && !st.cfg.bad;

  // System-clock side: straps, data ready, result store, commands
  always_comb begin
    nx = st;
    pend = st.pending;
    nx.cs_sync = {st.cs_sync[1:0], cs_n};
    nx.sent_sync = {st.sent_sync[0], tx_sent_r};
    nx.got_sync = {st.got_sync[0], rx_got_r};
    nx.strap_s1 = {interface_mode_strap, word_size_strap, hamming_strap};
    nx.strap_s2 = st.strap_s1;
    nx.cmd_valid = 1'b0;
    if (st.boot != ASPH_STRAP_DONE) begin
      nx.boot = st.boot + 2'h1;
      if (st.boot == ASPH_STRAP_SETTLE) begin
        nx.cfg = asph_straps(asph_pin_t'(st.strap_s2[5:4]),
          asph_pin_t'(st.strap_s2[3:2]),
          asph_pin_t'(st.strap_s2[1:0]));
      end
    end
    cs_rise = st.cs_sync[1] & ~st.cs_sync[2];
    rx_field = {rx_cmd_r[31:16], 8'h00};
    rx_hb = rx_cmd_r[15:8];
    if (st.cfg.wsz == ASPH_W32) begin
      rx_field = rx_cmd_r[31:8];
      rx_hb = rx_cmd_r[7:0];
    end
    rxd = '{data: rx_field, fixed: 1'b0, err: 1'b0};
    if (st.cfg.ham_en) begin
      rxd = asph_ham_check(rx_field, rx_hb);
      if (st.cfg.wsz == ASPH_W24 && rxd.data[7:0] != 8'h00) begin
        rxd.err = 1'b1;
      end
    end
    if (st.pulse_cnt != '0) begin
      nx.pulse_cnt = st.pulse_cnt - 1'b1;
      if (st.pulse_cnt == CNT_W'(1)) nx.data_ready_n_line_n = 1'b0;
    end
    if (cs_rise) begin
      nx.data_ready_n_line_n = 1'b1;
      nx.pulse_cnt = '0;
      if (st.sent_sync[1]) pend = 1'b0;
      if (st.got_sync[1]) begin
        nx.cmd = rxd.data[23:8];
        nx.cmd_fixed = rxd.fixed;
        nx.cmd_err = rxd.err;
        nx.cmd_valid = 1'b1;
      end
    end
    // A result is loaded only with chip select high; a live frame
    // could otherwise see its words change under it.
    take = conv_valid && !pend && st.cs_sync[1]
      && (st.boot == ASPH_STRAP_DONE);
    ovr_evt = conv_valid && !take && (st.boot == ASPH_STRAP_DONE);
    if (take) begin
      nx.frame[0] = asph_mk_word({status_word, 8'h00}, st.cfg.wsz,
        st.cfg.ham_en);
      for (int i = 0; i < NUM_CH; i++) begin
        nx.frame[i+1] = asph_mk_word(conv_data[i], st.cfg.wsz,
          st.cfg.ham_en);
      end
      pend = 1'b1;
      nx.data_ready_n_line_n = 1'b0;
      nx.pulse_cnt = '0;
    end
    if (ovr_evt) begin
      nx.data_ready_n_line_n = 1'b1;
      nx.pulse_cnt = CNT_W'(HALF_MOD_CYC);
    end
    nx.pending = pend;
    nx.ovr = (st.ovr & ~overrun_clear) | ovr_evt;
    if (!rst_n) begin
      nx = '0;
      nx.cs_sync = 3'b111;
      nx.data_ready_n_line_n = 1'b1;
      nx.cfg = ASPH_CFG_RST;
    end
  end

  always_ff @(posedge clock) begin
    if (clk_en || !rst_n) st <= nx;
  end

  // Link side, rising edges: one output bit per edge, no byte framing
  always_comb begin
    tx_nx = tx;
    if (!tx.done) begin
      tx_nx.drive = 1'b1;
      tx_nx.bit_out = st.frame[tx.word][5'd31 - tx.bitn];
      if (tx.bitn == 5'(wb - 6'd1)) begin
        tx_nx.bitn = 5'h00;
        if (tx.word == 4'(NUM_CH)) tx_nx.done = 1'b1;
        else tx_nx.word = tx.word + 4'h1;
      end else begin
        tx_nx.bitn = tx.bitn + 5'h01;
      end
    end else begin
      tx_nx.drive = 1'b0;
    end
  end

  // Chip select high clears the frame at once, clock or not
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) tx <= '0;
    else tx <= tx_nx;
  end

  // Held across chip select so the system side can see a full read
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) tx_sent_r <= 1'b0;
    else tx_sent_r <= tx_nx.done;
  end

  // Link side, falling edges: only the first word is kept
  always_comb begin
    rx_nx = rx;
    if (rx.cnt < wb) begin
      rx_nx.sh = {rx.sh[30:0], serial_in_line};
      rx_nx.cnt = rx.cnt + 6'h01;
    end
  end
  assign rx_word = {rx.sh[30:0], serial_in_line} << (6'd32 - wb);

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) rx <= '0;
    else rx <= rx_nx;
  end

  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_got_r <= 1'b0;
      rx_cmd_r <= 32'h00000000;
    end else begin
      if (rx.cnt == 6'h00) rx_got_r <= 1'b0;
      if (rx.cnt == wb - 6'd1) begin
        rx_got_r <= 1'b1;
        rx_cmd_r <= rx_word;
      end
    end
  end

  assign serial_out_line = tx.bit_out;
  assign serial_out_oe = tx.drive & link_en;
  assign data_ready_n_line = st.data_ready_n_line_n;
  assign data_overrun_flag = st.ovr;
  assign cmd_valid = st.cmd_valid;
  assign cmd_word = st.cmd;
  assign cmd_fixed = st.cmd_fixed;
  assign cmd_error = st.cmd_err;
  assign cfg_async_mode = st.cfg.mode == ASPH_PIN_HIGH;
  assign cfg_hamming_en = st.cfg.ham_en;
  assign cfg_word_bits = wb;
  assign cfg_invalid = st.cfg.bad;

  property p_ovr_pulse;
    @(posedge clock) disable iff (!rst_n || !clk_en)
      (ovr_evt ##1 (!cs_rise && !ovr_evt && !take) [*2]) |=>
      (!data_ready_n_line && $past(data_ready_n_line, 2));
  endproperty
  a_ovr_pulse: assert property (p_ovr_pulse)
    else $error("data ready overrun pulse has wrong shape");

  property p_ovr_flag;
    @(posedge clock) disable iff (!rst_n || !clk_en)
      ovr_evt |=> data_overrun_flag;
  endproperty
  a_ovr_flag: assert property (p_ovr_flag)
    else $error("overrun did not set the flag");

  property p_ovr_keep;
    @(posedge clock) disable iff (!rst_n || !clk_en)
      ovr_evt |=> $stable(st.frame);
  endproperty
  a_ovr_keep: assert property (p_ovr_keep)
    else $error("overrun changed the output words");

  property p_take_low;
    @(posedge clock) disable iff (!rst_n || !clk_en)
      take |=> !data_ready_n_line && st.pending;
  endproperty
  a_take_low: assert property (p_take_low)
    else $error("new result did not pull data ready low");

  property p_frame_end;
    @(posedge clock) disable iff (!rst_n || !clk_en)
      (cs_rise && !take) |=> data_ready_n_line;
  endproperty
  a_frame_end: assert property (p_frame_end)
    else $error("data ready not high after frame end");

  property p_strap_hold;
    @(posedge clock) disable iff (!rst_n || !clk_en)
      (st.boot == ASPH_STRAP_DONE) |=> $stable(st.cfg);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("latched strap setting changed");

  property p_no_ham16;
    @(posedge clock) disable iff (!rst_n)
      (st.cfg.ham_en && st.cfg.wsz == ASPH_W16) |-> cfg_invalid;
  endproperty
  a_no_ham16: assert property (p_no_ham16)
    else $error("Hamming accepted with 16-bit words");

  property p_cmd_late;
    @(posedge clock) disable iff (!rst_n || !clk_en)
      cmd_valid |-> $past(cs_rise);
  endproperty
  a_cmd_late: assert property (p_cmd_late)
    else $error("command issued before the frame ended");

  property p_release;
    @(posedge sclk) disable iff (cs_n || !rst_n)
      tx.done |=> !serial_out_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("output still driven after last bit");

endmodule : asph_serial_port

// File: asph_host_model.sv
// Purpose: Host master model for the converter serial port.
// Assumes: Clock polarity 0, phase 1; link period 32 ns.
// Notes: Reports received frame bits with a strobe after each frame.
`timescale 1ns/1ns
module asph_host_model (
  output logic sclk,
  output logic cs_n,
  output logic serial_in_line,
  input wire logic serial_out_line,
  input wire logic serial_out_oe,
  output logic rx_stb,
  output logic [95:0] rx_bits,
  output logic oe_err
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in_line = 1'b0;
    rx_stb = 1'b0;
    rx_bits = '0;
    oe_err = 1'b0;
  end

  task automatic frame(input int nbits, input logic [95:0] tx,
                       input bit burst);
    int off;
    // Short frames are top-aligned in both bit vectors
    off = 96 - nbits;
    rx_bits = '0;
    cs_n = 1'b0;
    #45;
    for (int i = nbits - 1; i >= 0; i--) begin
      sclk = 1'b1;
      #2 serial_in_line = tx[i + off];
      #14 sclk = 1'b0;
      rx_bits[i + off] = serial_out_line;
      if (serial_out_oe !== 1'b1) oe_err = 1'b1;
      #16;
      if (burst && i % 8 == 0) #150;
    end
    // One more byte of clocks past the last bit: output must be off
    if (burst) begin
      repeat (8) begin
        #16 sclk = 1'b1;
        #16 sclk = 1'b0;
        if (serial_out_oe !== 1'b0) oe_err = 1'b1;
      end
    end
    // Released line must not keep its last level
    serial_in_line = ~serial_in_line;
    #40 cs_n = 1'b1;
    #5 if (serial_out_oe !== 1'b0) oe_err = 1'b1;
    rx_stb = 1'b1;
    #1 rx_stb = 1'b0;
  endtask : frame
endmodule : asph_host_model

// File: tb_adc_serial_port_hamming.sv
// Purpose: Self-checking bench for the converter serial host port.
// Assumes: Two channels; 32-bit then 24-bit words with Hamming.
// Notes: Expected frames and commands queue up; monitors pop them.
`timescale 1ns/1ns
module tb_adc_serial_port_hamming;
  import asph_pkg::*;
  localparam int NCH = 2;
  logic clock, rst_n, clk_en, sclk, cs_n, serial_in_line;
  logic serial_out_line, serial_out_oe, data_ready_n_line;
  logic [1:0] interface_mode_strap, word_size_strap, hamming_strap;
  logic conv_valid, overrun_clear, data_overrun_flag;
  logic [NCH-1:0][23:0] conv_data, exp_data;
  logic [15:0] status_word, cmd_word;
  logic cmd_valid, cmd_fixed, cmd_error;
  logic cfg_async_mode, cfg_hamming_en, cfg_invalid;
  logic [5:0] cfg_word_bits;
  logic rx_stb, oe_err;
  logic [95:0] rx_bits;
  int mismatches, samples_checked, cycles, seed;
  logic [95:0] frame_q[$];
  logic [18:0] cmd_q[$];

  asph_serial_port #(.NUM_CH(NCH)) dut_u (.clock, .rst_n, .clk_en,
    .sclk, .cs_n, .serial_in_line, .serial_out_line, .serial_out_oe,
    .data_ready_n_line, .interface_mode_strap, .word_size_strap,
    .hamming_strap, .conv_valid, .conv_data, .status_word,
    .overrun_clear, .data_overrun_flag, .cmd_valid, .cmd_word,
    .cmd_fixed, .cmd_error, .cfg_async_mode, .cfg_hamming_en,
    .cfg_word_bits, .cfg_invalid);
  asph_host_model host_u (.sclk, .cs_n, .serial_in_line,
    .serial_out_line, .serial_out_oe, .rx_stb, .rx_bits, .oe_err);

  always #50 clock = ~clock;

  function automatic logic [7:0] ham(input logic [23:0] p);
    logic [4:0] h;
    int pos;
    h = '0;
    pos = 2;
    for (int i = 23; i >= 0; i--) begin
      pos++;
      if ((pos & (pos - 1)) == 0) pos++;
      if (p[i]) h ^= pos[4:0];
    end
    return {h, ^p ^ ^h, ^p[23:12], 1'b0};
  endfunction : ham

  function automatic logic [31:0] word(input logic [23:0] p);
    return {p, ham(p)};
  endfunction : word

  function automatic logic [23:0] word24(input logic [23:0] p);
    return {p[23:8], ham({p[23:8], 8'h00})};
  endfunction : word24

  task automatic check(input logic [95:0] got, input logic [95:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic boot(input logic [1:0] m, w, h);
    interface_mode_strap = m;
    word_size_strap = w;
    hamming_strap = h;
    rst_n = 1'b0;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    repeat (6) @(negedge clock);
  endtask : boot

  task automatic strap_case(input logic [1:0] m, w, h,
                            input logic [8:0] e);
    boot(m, w, h);
    if (e[6]) check(96'(cfg_invalid), 96'(1'b1), "cfg invalid");
    else check(96'({cfg_async_mode, cfg_hamming_en, cfg_invalid,
                    cfg_word_bits}), 96'(e), "cfg");
  endtask : strap_case

  task automatic conv(input bit acc);
    logic [NCH-1:0][23:0] d;
    int hi;
    d[0] = 24'($random(seed));
    d[1] = 24'($random(seed));
    hi = 0;
    @(negedge clock);
    conv_data = d;
    conv_valid = 1'b1;
    @(negedge clock);
    conv_valid = 1'b0;
    if (acc) begin
      exp_data = d;
      check(96'(data_ready_n_line), 96'(1'b0), "ready low");
    end else begin
      repeat (4) begin
        hi += int'(data_ready_n_line);
        @(negedge clock);
      end
      check(96'(hi), 96'(ASPH_HALF_MOD_CYC), "pulse");
      check(96'(data_overrun_flag), 96'(1'b1), "overrun");
    end
  endtask : conv

  task automatic read_frame(input logic [31:0] flip, input bit burst,
                            input logic [1:0] flags, input bit w24);
    logic [15:0] cmd;
    cmd = 16'($random(seed));
    cmd_q.push_back({~flags[0], cmd, flags});
    if (w24) begin
      frame_q.push_back({word24({status_word, 8'h00}),
                         word24(exp_data[0]), word24(exp_data[1]),
                         24'h0});
      host_u.frame(72, {word24({cmd, 8'h00}), 72'h0}, burst);
    end else begin
      frame_q.push_back({word({status_word, 8'h00}), word(exp_data[0]),
                         word(exp_data[1])});
      host_u.frame(96, {word({cmd, 8'h00}) ^ flip, 64'h0}, burst);
    end
    for (int i = 0; i < 8 && data_ready_n_line !== 1'b1; i++)
      @(negedge clock);
    check(96'(data_ready_n_line), 96'(1'b1), "ready high");
  endtask : read_frame

  always @(posedge rx_stb) begin
    if (frame_q.size() == 0) check(96'(1), 96'(0), "extra frame");
    else check(rx_bits, frame_q.pop_front(), "frame");
  end

  always @(negedge clock) begin
    if (cmd_valid === 1'b1) begin
      if (cmd_q.size() == 0) check(96'(1), 96'(0), "extra cmd");
      else begin
        logic [18:0] e;
        e = cmd_q.pop_front();
        check(96'({cmd_fixed, cmd_error}), 96'(e[1:0]), "flags");
        if (e[18]) check(96'(cmd_word), 96'(e[17:2]), "cmd");
      end
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      $display("Error at %0t: timeout", $time);
      end_of_test;
    end
  end

  initial begin
    seed = 32'hF750F6E5;
    clock = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    conv_valid = 1'b0;
    overrun_clear = 1'b0;
    conv_data = '0;
    exp_data = '0;
    status_word = 16'($random(seed));
    strap_case(2'h1, 2'h1, 2'h1, {3'h6, 6'h20});
    strap_case(2'h1, 2'h0, 2'h1, {3'h6, 6'h18});
    strap_case(2'h1, 2'h2, 2'h1, {3'h1, 6'h00});
    strap_case(2'h1, 2'h1, 2'h0, {3'h4, 6'h20});
    strap_case(2'h1, 2'h0, 2'h0, {3'h4, 6'h18});
    strap_case(2'h1, 2'h2, 2'h0, {3'h4, 6'h10});
    strap_case(2'h1, 2'h1, 2'h2, {3'h1, 6'h00});
    strap_case(2'h0, 2'h1, 2'h1, {3'h2, 6'h20});
    boot(2'h1, 2'h1, 2'h1);
    conv(1'b1);
    read_frame(32'h0, 1'b0, 2'h0, 1'b0);
    conv(1'b1);
    read_frame(32'h1 << (8 + ({$random(seed)} % 24)), 1'b1, 2'h2,
               1'b0);
    conv(1'b1);
    read_frame(32'h3 << (8 + ({$random(seed)} % 23)), 1'b0, 2'h1,
               1'b0);
    conv(1'b1);
    conv(1'b0);
    read_frame(32'h0, 1'b1, 2'h0, 1'b0);
    @(negedge clock);
    overrun_clear = 1'b1;
    @(negedge clock);
    overrun_clear = 1'b0;
    @(negedge clock);
    check(96'(data_overrun_flag), 96'(1'b0), "flag clear");
    boot(2'h1, 2'h0, 2'h1);
    conv(1'b1);
    read_frame(32'h0, 1'b1, 2'h0, 1'b1);
    repeat (10) @(negedge clock);
    check(96'(oe_err), 96'(1'b0), "drive enable");
    check(96'(frame_q.size() + cmd_q.size()), 96'(0), "results left");
    end_of_test;
  end
endmodule : tb_adc_serial_port_hamming
